// ===== rtl/icms_monitor.sv
/*
 One reference input activity monitor with loss detect and re-validation.
 Assumes the input level and the divided reference tick are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module icms_monitor
    import icms_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic clk_in_i,
    input wire logic diff_zero_i,
    input wire logic ref_tick_i,
    input wire logic ref_enable_i,
    input wire logic block_i,
    input wire logic [7:0] reval_count_i,
    output logic valid_o
);
    logic prev_reg;
    logic prev_next;
    logic [1:0] miss_reg;
    logic [1:0] miss_next;
    logic valid_reg;
    logic valid_next;
    logic [7:0] rv_reg;
    logic [7:0] rv_next;
    logic edge_seen;
    logic tick;

    assign edge_seen = clk_in_i & ~prev_reg;
    // Without the divided reference no tick arrives and no missing edge is counted
    assign tick = ref_tick_i & ref_enable_i;

    always_comb
    begin
        prev_next = clk_in_i;
        miss_next = miss_reg;
        valid_next = valid_reg;
        rv_next = rv_reg;
        if (block_i)
        begin
            valid_next = 1'b1;
            miss_next = 2'h0;
            rv_next = 8'h00;
        end
        else if (valid_reg)
        begin
            // A static input never edges, so ticks pile up; slow ticks delay this
            if (edge_seen)
                miss_next = 2'h0;
            else if (tick)
                miss_next = miss_reg + 2'h1;
            if (diff_zero_i || (tick && !edge_seen && miss_reg == ICMS_MISS_LIMIT - 2'h1))
            begin
                valid_next = 1'b0;
                rv_next = 8'h00;
                miss_next = 2'h0;
            end
        end
        else
        begin
            if (edge_seen && !diff_zero_i)
            begin
                miss_next = 2'h0;
                rv_next = rv_reg + 8'h01;
                // A count of zero acts as one
                if (rv_reg + 8'h01 >= reval_count_i)
                begin
                    valid_next = 1'b1;
                    rv_next = 8'h00;
                end
            end
            else if (diff_zero_i)
                rv_next = 8'h00;
            else if (tick)
            begin
                if (miss_reg == ICMS_MISS_LIMIT - 2'h1)
                    rv_next = 8'h00;
                else
                    miss_next = miss_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            prev_reg <= 1'b0;
            miss_reg <= 2'h0;
            valid_reg <= 1'b1;
            rv_reg <= 8'h00;
        end
        else
        begin
            prev_reg <= prev_next;
            miss_reg <= miss_next;
            valid_reg <= valid_next;
            rv_reg <= rv_next;
        end
    end

    assign valid_o = valid_reg;
endmodule
`default_nettype wire

// ===== rtl/icms_top.sv
/*
 Redundant reference supervisor: two input monitors, four selection modes,
 hold-off counter, holdover word freeze and the register port.
 Assumes all inputs are synchronous to mclk_i; ticks are one-cycle pulses.
*/
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module icms_top
    import icms_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [1:0] clk_in_i,
    input wire logic [1:0] diff_zero_i,
    input wire logic ref_tick_i,
    input wire logic holdoff_tick_i,
    input wire logic [ICMS_WORD_W-1:0] live_word_i,
    input wire logic [ICMS_AW-1:0] addr_i,
    input wire logic [ICMS_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [ICMS_DW-1:0] rdata_o,
    output logic active_input_o,
    output logic holdover_o,
    output logic ref_ok_o,
    output logic [ICMS_WORD_W-1:0] freq_word_o
);
    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [3:0] prio_reg;
    logic [3:0] prio_next;
    logic [7:0] reval_reg;
    logic [7:0] reval_next;
    logic [7:0] hstart_reg;
    logic [7:0] hstart_next;
    logic [1:0] los_reg;
    logic [1:0] los_next;
    logic refloss_reg;
    logic refloss_next;
    logic ref_ok_reg;
    logic ref_ok_next;
    logic [ICMS_DW-1:0] rdata_reg;
    logic [ICMS_DW-1:0] rdata_next;
    logic [1:0] valid_prev_reg;
    logic [1:0] valid;
    logic [1:0] rise;
    logic [1:0] fall;
    logic prio_wr;
    logic status_wr;
    icms_mode_t mode;
    logic sel_field;
    logic revert_en;
    logic block;
    logic pd;

    assign mode = icms_mode_t'(ctrl_reg[ICMS_CTRL_MODE_LSB +: 2]);
    assign sel_field = ctrl_reg[ICMS_CTRL_SEL_BIT];
    assign revert_en = ctrl_reg[ICMS_CTRL_REVERT_BIT];
    assign block = ctrl_reg[ICMS_CTRL_BLOCK_BIT];
    assign pd = ctrl_reg[ICMS_CTRL_PD_BIT];
    assign prio_wr = wr_i && addr_i == ICMS_ADDR_PRIO;
    assign status_wr = wr_i && addr_i == ICMS_ADDR_STATUS;

    // ************************************************************
    // Input monitors
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_mon
            icms_monitor u_mon (
                .mclk_i(mclk_i),
                .resetn_i(resetn_i),
                .clk_in_i(clk_in_i[gi]),
                .diff_zero_i(diff_zero_i[gi]),
                .ref_tick_i(ref_tick_i),
                .ref_enable_i(~pd),
                .block_i(block),
                .reval_count_i(reval_reg),
                .valid_o(valid[gi])
            );
        end
    endgenerate

    assign rise = valid & ~valid_prev_reg;
    assign fall = ~valid & valid_prev_reg;

    // ************************************************************
    // Selection state machine
    // ************************************************************
    icms_sel_state_t st_reg;
    icms_sel_state_t st_next;
    logic act_reg;
    logic act_next;
    logic hold_reg;
    logic hold_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic other;
    logic [1:0] prio_act;
    logic [1:0] prio_oth;
    logic [3:0] prio_eff;
    logic revert;

    assign other = ~act_reg;
    // A priority write is judged with the levels being written
    assign prio_eff = prio_wr ? wdata_i[3:0] : prio_reg;
    assign prio_act = act_reg ? prio_eff[3:2] : prio_eff[1:0];
    assign prio_oth = act_reg ? prio_eff[1:0] : prio_eff[3:2];
    // Only a strictly higher priority pulls the selection back
    assign revert = ((revert_en && rise[other]) || prio_wr) && valid[other]
                    && prio_oth > prio_act;

    always_comb
    begin
        act_next = act_reg;
        st_next = ICMS_SEL_RUN;
        hold_next = 1'b0;
        cnt_next = cnt_reg;
        case (mode)
            ICMS_MODE_MANUAL:
                act_next = sel_field;
            ICMS_MODE_SHORT_HOLD:
            begin
                act_next = sel_field;
                hold_next = ~valid[sel_field];
            end
            ICMS_MODE_AUTO:
            begin
                // No valid input: stay put, no holdover, PLL stays unlocked
                if (!valid[act_reg] && valid[other])
                    act_next = other;
                else if (revert)
                    act_next = other;
            end
            ICMS_MODE_AUTO_HOLD:
            begin
                case (st_reg)
                    ICMS_SEL_RUN:
                    begin
                        if (!valid[act_reg])
                        begin
                            hold_next = 1'b1;
                            cnt_next = hstart_reg;
                            st_next = ICMS_SEL_HOLDOFF;
                        end
                        else if (revert)
                            act_next = other;
                    end
                    ICMS_SEL_HOLDOFF:
                    begin
                        hold_next = 1'b1;
                        st_next = ICMS_SEL_HOLDOFF;
                        // Counter only runs here; revertive is ignored meanwhile
                        if (cnt_reg == 8'h00)
                        begin
                            cnt_next = hstart_reg;
                            if (valid[act_reg])
                            begin
                                hold_next = 1'b0;
                                st_next = ICMS_SEL_RUN;
                            end
                            else if (valid[other])
                            begin
                                act_next = other;
                                hold_next = 1'b0;
                                st_next = ICMS_SEL_RUN;
                            end
                            else
                                st_next = ICMS_SEL_WAIT;
                        end
                        else if (holdoff_tick_i)
                            cnt_next = cnt_reg - 8'h01;
                    end
                    ICMS_SEL_WAIT:
                    begin
                        hold_next = 1'b1;
                        st_next = ICMS_SEL_WAIT;
                        if (valid[act_reg])
                        begin
                            hold_next = 1'b0;
                            st_next = ICMS_SEL_RUN;
                        end
                        else if (valid[other])
                        begin
                            act_next = other;
                            hold_next = 1'b0;
                            st_next = ICMS_SEL_RUN;
                        end
                    end
                    default:
                        st_next = ICMS_SEL_RUN;
                endcase
            end
            default:
                act_next = sel_field;
        endcase
    end

    // ************************************************************
    // Status and holdover word
    // ************************************************************
    logic [ICMS_WORD_W-1:0] word_reg;
    logic [ICMS_WORD_W-1:0] word_next;

    // Freezing the last locked word is the holdover estimate
    assign word_next = hold_reg ? word_reg : live_word_i;
    assign ref_ok_next = valid[act_reg] && !hold_reg;

    always_comb
    begin
        los_next = los_reg;
        refloss_next = refloss_reg;
        // Clear only an input that is valid again; a new loss wins
        if (status_wr)
            los_next = los_reg & ~(wdata_i[ICMS_ST_LOS_LSB +: 2] & valid);
        los_next = los_next | fall;
        if (status_wr && wdata_i[ICMS_ST_REFLOSS_BIT] && ref_ok_reg)
            refloss_next = 1'b0;
        if (ref_ok_reg && !ref_ok_next)
            refloss_next = 1'b1;
    end

    // ************************************************************
    // Register port
    // ************************************************************
    always_comb
    begin
        ctrl_next = ctrl_reg;
        prio_next = prio_reg;
        reval_next = reval_reg;
        hstart_next = hstart_reg;
        rdata_next = '0;
        if (wr_i)
        begin
            case (addr_i)
                ICMS_ADDR_CTRL: ctrl_next = {2'b00, wdata_i[5:0]};
                ICMS_ADDR_PRIO: prio_next = wdata_i[3:0];
                ICMS_ADDR_REVAL: reval_next = wdata_i;
                ICMS_ADDR_HOLDOFF: hstart_next = wdata_i;
                default: ctrl_next = ctrl_reg;
            endcase
        end
        if (rd_i)
        begin
            case (addr_i)
                ICMS_ADDR_CTRL: rdata_next = ctrl_reg;
                ICMS_ADDR_PRIO: rdata_next = {4'h0, prio_reg};
                ICMS_ADDR_REVAL: rdata_next = reval_reg;
                ICMS_ADDR_HOLDOFF: rdata_next = hstart_reg;
                ICMS_ADDR_STATUS:
                begin
                    rdata_next[ICMS_ST_ACT_BIT] = act_reg;
                    rdata_next[ICMS_ST_VALID_LSB +: 2] = valid;
                    rdata_next[ICMS_ST_LOS_LSB +: 2] = los_reg;
                    rdata_next[ICMS_ST_REFOK_BIT] = ref_ok_reg;
                    rdata_next[ICMS_ST_REFLOSS_BIT] = refloss_reg;
                    rdata_next[ICMS_ST_HOLD_BIT] = hold_reg;
                end
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_reg <= ICMS_CTRL_RESET;
            prio_reg <= ICMS_PRIO_RESET;
            reval_reg <= ICMS_REVAL_RESET;
            hstart_reg <= ICMS_HOLDOFF_RESET;
            los_reg <= 2'b00;
            refloss_reg <= 1'b0;
            ref_ok_reg <= 1'b0;
            rdata_reg <= '0;
            valid_prev_reg <= 2'b11;
            st_reg <= ICMS_SEL_RUN;
            act_reg <= 1'b0;
            hold_reg <= 1'b0;
            cnt_reg <= 8'h00;
            word_reg <= '0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            prio_reg <= prio_next;
            reval_reg <= reval_next;
            hstart_reg <= hstart_next;
            los_reg <= los_next;
            refloss_reg <= refloss_next;
            ref_ok_reg <= ref_ok_next;
            rdata_reg <= rdata_next;
            valid_prev_reg <= valid;
            st_reg <= st_next;
            act_reg <= act_next;
            hold_reg <= hold_next;
            cnt_reg <= cnt_next;
            word_reg <= word_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign active_input_o = act_reg;
    assign holdover_o = hold_reg;
    assign ref_ok_o = ref_ok_reg;
    assign freq_word_o = word_reg;
endmodule
`default_nettype wire

// ===== shared/icms_pkg.sv
/*
 Constants, register map and mode encodings of the input clock monitor
 and selector. Assumes an 8-bit register port with one-cycle read data.
*/
package icms_pkg;
    // ************************************************************
    // Register port
    // ************************************************************
    localparam int ICMS_AW = 3;
    localparam int ICMS_DW = 8;
    localparam logic [2:0] ICMS_ADDR_CTRL = 3'h0;
    localparam logic [2:0] ICMS_ADDR_PRIO = 3'h1;
    localparam logic [2:0] ICMS_ADDR_REVAL = 3'h2;
    localparam logic [2:0] ICMS_ADDR_HOLDOFF = 3'h3;
    localparam logic [2:0] ICMS_ADDR_STATUS = 3'h4;
    // ************************************************************
    // Control field positions
    // ************************************************************
    localparam int ICMS_CTRL_MODE_LSB = 0;
    localparam int ICMS_CTRL_SEL_BIT = 2;
    localparam int ICMS_CTRL_REVERT_BIT = 3;
    localparam int ICMS_CTRL_BLOCK_BIT = 4;
    localparam int ICMS_CTRL_PD_BIT = 5;
    // ************************************************************
    // Status field positions
    // ************************************************************
    localparam int ICMS_ST_ACT_BIT = 0;
    localparam int ICMS_ST_VALID_LSB = 1;
    localparam int ICMS_ST_LOS_LSB = 3;
    localparam int ICMS_ST_REFOK_BIT = 5;
    localparam int ICMS_ST_REFLOSS_BIT = 6;
    localparam int ICMS_ST_HOLD_BIT = 7;
    // ************************************************************
    // Reset values and limits
    // ************************************************************
    localparam logic [7:0] ICMS_CTRL_RESET = 8'h20;
    localparam logic [3:0] ICMS_PRIO_RESET = 4'h0;
    localparam logic [7:0] ICMS_REVAL_RESET = 8'h01;
    localparam logic [7:0] ICMS_HOLDOFF_RESET = 8'h00;
    localparam logic [1:0] ICMS_MISS_LIMIT = 2'h3;
    localparam int ICMS_WORD_W = 16;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        ICMS_MODE_MANUAL = 2'b00,
        ICMS_MODE_AUTO = 2'b01,
        ICMS_MODE_SHORT_HOLD = 2'b10,
        ICMS_MODE_AUTO_HOLD = 2'b11
    } icms_mode_t;
    typedef enum logic [1:0] {
        ICMS_SEL_RUN = 2'b00,
        ICMS_SEL_HOLDOFF = 2'b01,
        ICMS_SEL_WAIT = 2'b10
    } icms_sel_state_t;
endpackage

// ===== tb/icms_ref_src.sv
/*
 Model of the two redundant reference sources and the divided PLL ticks.
 Assumes the bench starts and stops each source between clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module icms_ref_src
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [1:0] run_i,
    input wire logic [1:0] zero_i,
    output logic [1:0] clk_o,
    output logic [1:0] dz_o,
    output logic ref_tick_o,
    output logic holdoff_tick_o
);
    // ******
    // Sources
    // ******
    logic [1:0] div_reg;
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            clk_o <= 2'h0;
            div_reg <= 2'h0;
        end
        else
        begin
            // A stopped source stays static, never floats
            clk_o <= clk_o ^ run_i;
            div_reg <= div_reg + 2'h1;
        end
    end
    assign dz_o = zero_i;
    // Divider matched to the input rate, so no false loss
    assign ref_tick_o = div_reg[0];
    assign holdoff_tick_o = (div_reg == 2'h3);
endmodule
`default_nettype wire

// ===== tb/icms_top_chk.sv
/*
 Port checker for the reference supervisor, bound to icms_top.
 Assumes one clock domain and registered outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module icms_top_chk
    import icms_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [ICMS_WORD_W-1:0] live_word_i,
    input wire logic [ICMS_AW-1:0] addr_i,
    input wire logic [ICMS_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [ICMS_DW-1:0] rdata_o,
    input wire logic active_input_o,
    input wire logic holdover_o,
    input wire logic ref_ok_o,
    input wire logic [ICMS_WORD_W-1:0] freq_word_o
);
    // ******
    // Control shadow
    // ******
    logic [5:0] ctrl_reg;
    logic [5:0] ctrl_next;
    logic [1:0] age_reg;
    logic [1:0] age_next;
    always_comb
    begin
        ctrl_next = ctrl_reg;
        age_next = (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
        if (wr_i && addr_i == ICMS_ADDR_CTRL)
        begin
            ctrl_next = wdata_i[5:0];
            age_next = 2'h0;
        end
    end
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_reg <= ICMS_CTRL_RESET[5:0];
            age_reg <= 2'h3;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            age_reg <= age_next;
        end
    end
    // ******
    // Assertions
    // ******
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    a_read_idle: assert property (
        !$past(rd_i) |-> rdata_o == 8'h00) else $error("read data outside read cycle");
    a_ctrl_readback: assert property (
        rd_i && addr_i == ICMS_ADDR_CTRL |=> rdata_o == {2'b00, $past(ctrl_reg)})
        else $error("control read back wrong");
    a_status_mirror: assert property (
        rd_i && addr_i == ICMS_ADDR_STATUS |=> rdata_o[0] == $past(active_input_o)
        && rdata_o[7] == $past(holdover_o)) else $error("status disagrees with ports");
    // Settle time allowed after a mode write
    a_manual_select: assert property (
        age_reg >= 2'h2 && !ctrl_reg[0] |-> active_input_o == ctrl_reg[2])
        else $error("selection differs from select field");
    a_auto_no_hold: assert property (
        age_reg == 2'h3 && !ctrl_reg[1] |-> !holdover_o) else $error("holdover in mode");
    a_hold_not_ok: assert property (
        holdover_o |-> !ref_ok_o) else $error("reference ok during holdover");
    a_word_frozen: assert property (
        holdover_o && $past(holdover_o) |-> $stable(freq_word_o)) else $error("word moved");
    a_word_tracks: assert property (
        !holdover_o && !$past(holdover_o) |-> freq_word_o == $past(live_word_i))
        else $error("word not tracking live value");
endmodule
bind icms_top icms_top_chk u_chk
(
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .live_word_i(live_word_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .active_input_o(active_input_o),
    .holdover_o(holdover_o),
    .ref_ok_o(ref_ok_o),
    .freq_word_o(freq_word_o)
);
`default_nettype wire

// ===== tb/icms_top_tb.sv
/*
 Self-checking bench for icms_top: register tasks and scenario sequence.
 Assumes the source model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) \
            begin \
            mismatches++; \
            $display("[ERR] %s expected %h seen %h", nm, ex, got); \
        end \
    end
module icms_top_tb
    import icms_pkg::*;
;
    logic mclk_i;
    logic resetn_i;
    logic [1:0] run;
    logic [1:0] zero;
    logic [1:0] clk_in;
    logic [1:0] dz;
    logic ref_tick;
    logic ho_tick;
    logic word_run;
    logic [ICMS_WORD_W-1:0] live_word;
    logic [ICMS_WORD_W-1:0] freq_word;
    logic [ICMS_AW-1:0] addr;
    logic [ICMS_DW-1:0] wdata;
    logic [ICMS_DW-1:0] rdata;
    logic wr;
    logic rd;
    logic act;
    logic hold;
    logic ref_ok;
    int mismatches;
    int samples_checked;
    int cycles;
    icms_ref_src u_src (.mclk_i(mclk_i), .resetn_i(resetn_i), .run_i(run), .zero_i(zero),
        .clk_o(clk_in), .dz_o(dz), .ref_tick_o(ref_tick), .holdoff_tick_o(ho_tick));
    icms_top u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .clk_in_i(clk_in),
        .diff_zero_i(dz), .ref_tick_i(ref_tick), .holdoff_tick_i(ho_tick),
        .live_word_i(live_word), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .active_input_o(act), .holdover_o(hold), .ref_ok_o(ref_ok),
        .freq_word_o(freq_word));
    initial
    begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    // ******
    // Register port tasks
    // ******
    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
        @(posedge mclk_i);
    endtask
    // Read data stands one cycle only, so sample just after the edge
    task automatic chk(input string nm, input logic [2:0] a, input logic [7:0] m,
        input logic [7:0] ex);
        logic [7:0] d;
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 d = rdata & m;
        `CHK(nm, ex, d)
        @(posedge mclk_i);
    endtask
    task automatic wait_hold(input logic lvl);
        repeat (80) if (hold !== lvl) @(posedge mclk_i);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge mclk_i)
    begin
        cycles <= cycles + 1;
        if (!resetn_i)
            live_word <= '0;
        else if (word_run)
            live_word <= live_word + 1'b1;
        if (cycles == 6000)
        begin
            mismatches++;
            close_out();
        end
    end
    // ******
    // Scenarios
    // ******
    initial
    begin
        resetn_i = 1'b0;
        {run, zero, addr, wdata, wr, rd, word_run} = '0;
        {mismatches, samples_checked} = '0;
        run = 2'b11;
        idle(20);
        resetn_i <= 1'b1;
        idle(4);
        word_run <= 1'b1;
        chk("ctrl", ICMS_ADDR_CTRL, 8'hFF, 8'h20);
        chk("prio", ICMS_ADDR_PRIO, 8'hFF, 8'h00);
        chk("reval", ICMS_ADDR_REVAL, 8'hFF, 8'h01);
        chk("holdoff", ICMS_ADDR_HOLDOFF, 8'hFF, 8'h00);
        chk("status", ICMS_ADDR_STATUS, 8'h9F, 8'h06);
        wreg(ICMS_ADDR_CTRL, 8'hC0);
        chk("ctrl", ICMS_ADDR_CTRL, 8'hFF, 8'h00);
        wreg(3'h6, 8'h5A);
        chk("unmapped", 3'h6, 8'hFF, 8'h00);
        wreg(ICMS_ADDR_CTRL, 8'h04);
        idle(16);
        chk("status", ICMS_ADDR_STATUS, 8'h9F, 8'h07);
        run <= 2'b01;
        idle(16);
        chk("status", ICMS_ADDR_STATUS, 8'hBF, 8'h13);
        wreg(ICMS_ADDR_STATUS, 8'h10);
        run <= 2'b11;
        idle(16);
        chk("status", ICMS_ADDR_STATUS, 8'hBF, 8'h37);
        wreg(ICMS_ADDR_STATUS, 8'h10);
        chk("status", ICMS_ADDR_STATUS, 8'h18, 8'h00);
        zero <= 2'b01;
        idle(6);
        chk("status", ICMS_ADDR_STATUS, 8'h06, 8'h04);
        zero <= 2'b00;
        wreg(ICMS_ADDR_CTRL, 8'h14);
        // Drop the loss left by the zero-voltage case once blocking is set
        wreg(ICMS_ADDR_STATUS, 8'h08);
        run <= 2'b10;
        idle(16);
        chk("status", ICMS_ADDR_STATUS, 8'h1E, 8'h06);
        run <= 2'b11;
        idle(16);
        wreg(ICMS_ADDR_CTRL, 8'h01);
        wreg(ICMS_ADDR_PRIO, 8'h03);
        chk("status", ICMS_ADDR_STATUS, 8'h81, 8'h00);
        wreg(ICMS_ADDR_PRIO, 8'h0C);
        chk("status", ICMS_ADDR_STATUS, 8'h81, 8'h01);
        run <= 2'b01;
        idle(16);
        chk("status", ICMS_ADDR_STATUS, 8'h81, 8'h00);
        run <= 2'b00;
        idle(16);
        chk("status", ICMS_ADDR_STATUS, 8'hA7, 8'h00);
        run <= 2'b10;
        idle(20);
        chk("status", ICMS_ADDR_STATUS, 8'hA1, 8'h21);
        run <= 2'b11;
        idle(16);
        wreg(ICMS_ADDR_STATUS, 8'h58);
        wreg(ICMS_ADDR_PRIO, 8'h03);
        wreg(ICMS_ADDR_HOLDOFF, 8'h04);
        wreg(ICMS_ADDR_CTRL, 8'h03);
        chk("status", ICMS_ADDR_STATUS, 8'h81, 8'h00);
        run <= 2'b10;
        wait_hold(1'b1);
        chk("status", ICMS_ADDR_STATUS, 8'hA1, 8'h80);
        idle(40);
        chk("status", ICMS_ADDR_STATUS, 8'hA1, 8'h21);
        run <= 2'b00;
        wait_hold(1'b1);
        idle(60);
        chk("status", ICMS_ADDR_STATUS, 8'h81, 8'h81);
        wreg(ICMS_ADDR_STATUS, 8'h40);
        chk("status", ICMS_ADDR_STATUS, 8'h40, 8'h40);
        run <= 2'b01;
        wait_hold(1'b0);
        chk("status", ICMS_ADDR_STATUS, 8'hA1, 8'h20);
        wreg(ICMS_ADDR_STATUS, 8'h40);
        chk("status", ICMS_ADDR_STATUS, 8'h40, 8'h00);
        run <= 2'b11;
        idle(16);
        wreg(ICMS_ADDR_CTRL, 8'h06);
        idle(4);
        run <= 2'b01;
        wait_hold(1'b1);
        chk("status", ICMS_ADDR_STATUS, 8'hA1, 8'h81);
        run <= 2'b11;
        wait_hold(1'b0);
        chk("status", ICMS_ADDR_STATUS, 8'hA1, 8'h21);
        close_out();
    end
endmodule
`default_nettype wire
